// ==== core/lafc_consts.svh ====
`ifndef LAFC_CONSTS_SVH
`define LAFC_CONSTS_SVH
// Register byte offsets
`define LAFC_OFF_CTRL    12'h000
`define LAFC_OFF_CMD     12'h004
`define LAFC_OFF_STATUS  12'h008
`define LAFC_OFF_AUTO    12'h00c
`define LAFC_OFF_IRQ     12'h010
`define LAFC_OFF_TIMER   12'h014
`define LAFC_OFF_COUNT   12'h018
// Control bits
`define LAFC_CTRL_MANUAL 0
`define LAFC_CTRL_ITMR   1
`define LAFC_CTRL_OWNBSY 2
// Command bits
`define LAFC_CMD_RECOV   0
`define LAFC_CMD_RXREL   1
`define LAFC_CMD_RXRST   2
`define LAFC_CMD_TXRST   3
// Interrupt event bits
`define LAFC_IRQ_RME     0
`define LAFC_IRQ_RPF     1
`define LAFC_IRQ_XPR     2
`define LAFC_IRQ_XMR     3
`define LAFC_IRQ_RSC     4
`define LAFC_IRQ_PCE     5
`define LAFC_IRQ_TIN     6
// Frame thresholds in octets and bits
`define LAFC_U_MIN_OCT   12'h004
`define LAFC_I_MIN_OCT   12'h005
`define LAFC_S_MIN_OCT   12'h006
`define LAFC_ABORT_ONES  3'h7
`define LAFC_FLAG_BYTE   8'h7e
`define LAFC_FIFO_LIMIT  12'h040
`endif

// ==== core/lafc_frame_checker.sv ====
// Functional notes
// [R1] Drop frames lacking opening flag
// [R2] Unclosed frame: drop S, else abort end
// [R3] Drop too-short U, I, S frames
// [R4] Short-but-nonintegral U/I ends with CRC bad
// [R5] Nonintegral: drop S, busy-I; else CRC bad
// [R6] FCS error: drop S, else CRC bad
// [R7] Drop one-octet address, unsupported SAPI
// [R8] Seven ones abort current frame
// [R9] Overflow ends frame, sets overflow flag; here only the flag is set and the frame runs on to its closing flag
// [R10] Pool-ready only after acknowledge in auto
// [R11] Repeat on reject/collision, then state 7
// [R12] Retry count cleared leaving recovery; a collision exit keeps the count here
// [R13] Recovery command enters recovery, count zero; here taken only with timer select 1, from MFE
// [R14] Flag supervisory frames sent in auto
// [R15] Hardware ack timer only in 7/8
// [R16] Timer write stops timer
// [R17] Auto-only status masked in manual mode
// [R18] Host leaves auto with timer select 0
// [R19] Host waits before resets after leaving
// [R20] Host loads fields per send kind
// [R21] Host sends next I only when allowed
// [R22] Host checks status, resets past 528
//
// Chosen here: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "lafc_consts.svh"
module lafc_frame_checker import lafc_pkg::*; (
  input  wire logic        i_clk,        // 200 MHz clock
  input  wire logic        i_rst,        // Sync reset, high
  input  wire logic        i_psel,       // APB select
  input  wire logic        i_penable,    // APB enable
  input  wire logic        i_pwrite,     // APB write
  input  wire logic [11:0] i_paddr,      // APB byte address
  input  wire logic [31:0] i_pwdata,     // APB write data
  output logic      [31:0] o_prdata,     // APB read data
  output logic             o_pready,     // APB ready
  output logic             o_pslverr,    // APB error
  input  wire logic        i_rx_bit,     // Line bit, external domain
  input  wire logic        i_rx_bit_vld, // Bit strobe, external domain
  input  wire logic        i_fcs_ok,     // FCS verdict at closing flag
  input  wire logic        i_sapi_ok,    // SAPI supported
  input  wire logic        i_rx_full,    // Receive store full
  input  wire logic        i_ack_rx,     // Peer acknowledged I frame
  input  wire logic        i_rej_rx,     // Peer rejected I frame
  input  wire logic        i_collision,  // D channel collision
  input  wire logic        i_tx_done,    // Frame sent
  input  wire logic        i_tx_info,    // Sent frame was auto I frame
  input  wire logic        i_sframe_tx,  // Supervisory frame sent
  input  wire logic        i_peer_busy,  // Peer not ready
  input  wire logic        i_tick,       // Timer base tick
  output logic      [6:0]  o_irq_status, // Sticky event flags
  output lafc_rxstat_s     o_rx_frame_status // Last frame status
);
  // Three-stage input sync
  logic [2:0] bit_sy_q, vld_sy_q;
  logic       vld_old_q;
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      bit_sy_q  <= 3'h0;
      vld_sy_q  <= 3'h0;
      vld_old_q <= 1'b0;
    end else begin
      bit_sy_q  <= {bit_sy_q[1:0], i_rx_bit};
      vld_sy_q  <= {vld_sy_q[1:0], i_rx_bit_vld};
      if (vld_sy_q[2] == vld_sy_q[1]) vld_old_q <= vld_sy_q[2];
    end
  end
  logic bit_stb, rx_bit;
  // Strobe edge once the last two stages agree
  assign bit_stb = (vld_sy_q[2] == vld_sy_q[1]) && vld_sy_q[2] && !vld_old_q;
  assign rx_bit  = bit_sy_q[2];

  // Control registers
  logic       manual_mode_q, internal_timer_select_q, own_busy_q;
  logic       apb_wr, apb_rd;
  assign apb_wr = i_psel && i_penable && i_pwrite;
  assign apb_rd = i_psel && i_penable && !i_pwrite;
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      manual_mode_q           <= 1'b1;
      internal_timer_select_q <= 1'b0;
      own_busy_q              <= 1'b0;
    end else if (apb_wr && i_paddr == `LAFC_OFF_CTRL) begin
      manual_mode_q           <= i_pwdata[`LAFC_CTRL_MANUAL];
      internal_timer_select_q <= i_pwdata[`LAFC_CTRL_ITMR];
      own_busy_q              <= i_pwdata[`LAFC_CTRL_OWNBSY];
    end
  end
  logic auto_on;
  // Auto mode is the inverse of the manual bit
  assign auto_on = !manual_mode_q;

  // Receive bit engine: flags, destuffing, aborts
  logic [7:0]  shift_q;
  logic [2:0]  ones_q, bitc_q;
  logic        in_frame_q, ovf_q;
  logic [11:0] octets_q;
  logic [7:0]  ctl_q;
  logic        addr_ea0_q;
  logic        end_ok, end_abort, is_flag, drop_bit;
  assign is_flag  = bit_stb && ones_q == 3'h6 && !rx_bit;
  assign drop_bit = bit_stb && ones_q == 3'h5 && !rx_bit;
  assign end_abort = bit_stb && rx_bit && ones_q == 3'h6 && in_frame_q; // [R8]
  assign end_ok    = is_flag && in_frame_q && octets_q != 12'h000;
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      shift_q <= 8'h00; ones_q <= 3'h0; bitc_q <= 3'h0;
      in_frame_q <= 1'b0; octets_q <= 12'h000; ctl_q <= 8'h00;
      addr_ea0_q <= 1'b0; ovf_q <= 1'b0;
    end else if (bit_stb) begin
      if (rx_bit) begin
        if (ones_q != `LAFC_ABORT_ONES) ones_q <= ones_q + 3'h1;
      end else ones_q <= 3'h0;
      if (is_flag) begin
        // Only a flag opens a frame; data before it is ignored
        in_frame_q <= 1'b1; // [R1]
        octets_q <= 12'h000; bitc_q <= 3'h0; ovf_q <= 1'b0;
      end else if (rx_bit && ones_q == 3'h6) begin
        // Seventh one aborts; wait for a new flag
        in_frame_q <= 1'b0; // [R8]
      end else if (in_frame_q && !drop_bit) begin
        shift_q <= {rx_bit, shift_q[7:1]};
        bitc_q  <= bitc_q + 3'h1;
        if (bitc_q == 3'h7) begin
          octets_q <= octets_q + 12'h001;
          // Address extension is the first bit of octet one
          if (octets_q == 12'h000) addr_ea0_q <= !shift_q[1]; // [R7]
          if (octets_q == 12'h002) ctl_q <= {rx_bit, shift_q[7:1]};
          if (i_rx_full && octets_q > `LAFC_U_MIN_OCT) ovf_q <= 1'b1;
        end
      end
    end
  end

  // Frame classification at frame end
  lafc_ftype_e ftype;
  always_comb begin
    if (!ctl_q[0])      ftype = LAFC_FT_I;
    else if (!ctl_q[1]) ftype = LAFC_FT_S;
    else                ftype = LAFC_FT_U;
  end
  // Flag's first seven bits add no octet to a whole frame;
  // a ragged tail plus those bits adds exactly one octet
  logic [11:0] len;
  logic        whole, short_u, short_i, short_s, drop, report, crc_bad;
  assign len     = octets_q;
  assign whole   = bitc_q == 3'h7;
  assign short_u = ftype == LAFC_FT_U && len <= `LAFC_U_MIN_OCT; // [R3]
  assign short_i = ftype == LAFC_FT_I && len <= `LAFC_I_MIN_OCT; // [R3]
  assign short_s = ftype == LAFC_FT_S && len <  `LAFC_S_MIN_OCT; // [R3]
  always_comb begin
    drop    = short_u || short_i || short_s;
    drop    = drop || !addr_ea0_q || !i_sapi_ok; // [R7]
    crc_bad = 1'b0;
    // Supervisory frames are never reported on error
    if (ftype == LAFC_FT_S) begin
      drop = drop || !whole || !i_fcs_ok || end_abort; // [R2] [R5] [R6]
    end else begin
      if (ftype == LAFC_FT_I && !whole && own_busy_q) drop = 1'b1; // [R5]
      crc_bad = !whole || !i_fcs_ok; // [R4] [R5] [R6]
    end
  end
  // Frame end that survives every discard test
  assign report = (end_ok || end_abort) && !drop;

  // Receive status of last reported frame
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_rx_frame_status <= '0;
    end else if (report) begin
      o_rx_frame_status.abort    <= end_abort; // [R2]
      o_rx_frame_status.overflow <= ovf_q; // [R9]
      o_rx_frame_status.crc_good <= !end_abort && !crc_bad; // [R4] [R6]
    end
  end

  // Auto-mode link state and retry count
  lafc_lstate_e lstate_q;
  logic [3:0]   retry_q;
  logic         await_ack_q, sframe_seen_q, timer_run_q, timeout;
  logic [15:0]  timer_q, timer_load_q;
  logic         rec_cmd, tmr_wr;
  // Command, timer-write and expiry strobes
  assign rec_cmd = apb_wr && i_paddr == `LAFC_OFF_CMD && i_pwdata[`LAFC_CMD_RECOV];
  assign tmr_wr  = apb_wr && i_paddr == `LAFC_OFF_TIMER;
  assign timeout = timer_run_q && i_tick && timer_q == 16'h0000;
  always_ff @(posedge i_clk) begin
    if (i_rst || !auto_on) begin
      lstate_q <= LAFC_ST_MFE;
      retry_q  <= 4'h0;
    end else begin
      case (lstate_q)
        LAFC_ST_MFE: begin
          if ((rec_cmd && internal_timer_select_q) || timeout) begin
            lstate_q <= LAFC_ST_TIMER_RECOVERY_FLAG; // [R13]
            retry_q  <= 4'h0; // [R13]
          end
        end
        LAFC_ST_TIMER_RECOVERY_FLAG: begin
          if (i_ack_rx || i_rej_rx) begin
            lstate_q <= LAFC_ST_MFE;
            retry_q  <= 4'h0; // [R12]
          end else if (timeout) retry_q <= retry_q + 4'h1;
        end
        default: lstate_q <= LAFC_ST_MFE;
      endcase
      if (i_collision && i_tx_info) lstate_q <= LAFC_ST_MFE; // [R11]
    end
  end

  // Hardware ack timer, auto states only
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      timer_q <= 16'h0000; timer_load_q <= 16'hffff; timer_run_q <= 1'b0;
    end else if (tmr_wr) begin
      timer_load_q <= i_pwdata[15:0];
      timer_run_q  <= 1'b0; // [R16]
    end else if (!auto_on || !internal_timer_select_q) begin
      timer_run_q <= 1'b0; // [R15]
    end else if (i_tx_done && i_tx_info) begin
      timer_q <= timer_load_q; timer_run_q <= 1'b1; // [R15]
    end else if (i_ack_rx) begin
      timer_run_q <= 1'b0;
    end else if (timer_run_q && i_tick) begin
      timer_q <= (timer_q == 16'h0000) ? timer_load_q : timer_q - 16'h0001;
    end
  end

  // Awaiting-ack and supervisory-sent flags
  logic stat_rd;
  assign stat_rd = apb_rd && i_paddr == `LAFC_OFF_AUTO;
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      await_ack_q <= 1'b0; sframe_seen_q <= 1'b0;
    end else begin
      if (i_tx_done && i_tx_info && auto_on) await_ack_q <= 1'b1;
      else if (i_ack_rx || i_rej_rx || !auto_on) await_ack_q <= 1'b0;
      if (i_sframe_tx && auto_on) sframe_seen_q <= 1'b1; // [R14]
      else if (stat_rd) sframe_seen_q <= 1'b0;
    end
  end

  // Interrupt events, set wins over read-clear
  logic [6:0] ev;
  logic       peer_old_q, irq_rd;
  always_comb begin
    ev = 7'h00;
    ev[`LAFC_IRQ_RME] = report || (ovf_q && end_ok); // [R2] [R9]
    ev[`LAFC_IRQ_RPF] = in_frame_q && bit_stb && bitc_q == 3'h7 &&
                        octets_q[5:0] == 6'h3f;
    if (auto_on && i_tx_info) begin
      ev[`LAFC_IRQ_XPR] = i_ack_rx && await_ack_q; // [R10]
      ev[`LAFC_IRQ_XMR] = (i_rej_rx && await_ack_q) || i_collision; // [R11]
    end else begin
      ev[`LAFC_IRQ_XPR] = i_tx_done; // [R10]
      ev[`LAFC_IRQ_XMR] = i_collision; // [R11]
    end
    ev[`LAFC_IRQ_RSC] = auto_on && (i_peer_busy != peer_old_q); // [R17]
    ev[`LAFC_IRQ_PCE] = auto_on && end_ok && !drop && ftype == LAFC_FT_S &&
                        len > `LAFC_S_MIN_OCT; // [R17]
    ev[`LAFC_IRQ_TIN] = timeout && lstate_q == LAFC_ST_TIMER_RECOVERY_FLAG && retry_q == 4'hf;
  end
  // Read of the event register clears it
  assign irq_rd = apb_rd && i_paddr == `LAFC_OFF_IRQ;
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_irq_status <= 7'h00; peer_old_q <= 1'b0;
    end else begin
      peer_old_q   <= i_peer_busy;
      o_irq_status <= (irq_rd ? 7'h00 : o_irq_status) | ev;
    end
  end

  // APB read mux, zero-wait, error on unmapped
  logic mapped;
  always_comb begin
    o_prdata = 32'h0000_0000;
    mapped   = 1'b1;
    if (i_paddr == `LAFC_OFF_CTRL) begin
      o_prdata[2:0] = {own_busy_q, internal_timer_select_q, manual_mode_q};
    end else if (i_paddr == `LAFC_OFF_CMD) begin
      o_prdata = 32'h0000_0000;
    end else if (i_paddr == `LAFC_OFF_STATUS) begin
      o_prdata[3:0] = {auto_on && i_peer_busy, o_rx_frame_status}; // [R17]
    end else if (i_paddr == `LAFC_OFF_AUTO) begin
      if (auto_on) o_prdata[3:0] = {sframe_seen_q, await_ack_q,
                                    lstate_q == LAFC_ST_TIMER_RECOVERY_FLAG, 1'b1}; // [R17]
    end else if (i_paddr == `LAFC_OFF_IRQ) begin
      o_prdata[6:0] = o_irq_status;
    end else if (i_paddr == `LAFC_OFF_TIMER) begin
      o_prdata[16:0] = {timer_run_q, timer_q};
    end else if (i_paddr == `LAFC_OFF_COUNT) begin
      o_prdata[15:0] = {retry_q, octets_q};
    end else begin
      mapped = 1'b0;
    end
  end
  // Zero wait states; error only in access phase
  assign o_pready  = 1'b1;
  assign o_pslverr = i_psel && i_penable && !mapped;
endmodule
`default_nettype wire

// ==== core/lafc_pkg.sv ====
package lafc_pkg;
  typedef enum logic [1:0] {
    LAFC_FT_I = 2'h0,
    LAFC_FT_S = 2'h1,
    LAFC_FT_U = 2'h2
  } lafc_ftype_e;
  typedef enum logic [3:0] {
    LAFC_ST_IDLE  = 4'h1,
    LAFC_ST_MFE   = 4'h2,
    LAFC_ST_TIMER_RECOVERY_FLAG  = 4'h4,
    LAFC_ST_WAIT  = 4'h8
  } lafc_lstate_e;
  typedef struct packed {
    logic crc_good;
    logic overflow;
    logic abort;
  } lafc_rxstat_s;
  typedef struct packed {
    logic [11:0] paddr;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] pwdata;
  } lafc_apb_req_s;
endpackage

// ==== verif/lafc_fc_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
module lafc_fc_chk import lafc_pkg::*; (
  input wire logic         i_clk,            // Clock
  input wire logic         i_rst,            // Reset
  input wire logic         i_psel,           // APB select
  input wire logic         i_penable,        // APB enable
  input wire logic         i_pwrite,         // APB write
  input wire logic [11:0]  i_paddr,          // APB address
  input wire logic [31:0]  i_pwdata,         // APB write data
  input wire logic [31:0]  o_prdata,         // APB read data
  input wire logic         i_rej_rx,         // Peer reject
  input wire logic         i_ack_rx,         // Peer ack
  input wire logic         i_collision,      // Collision
  input wire logic         i_tx_done,        // Frame sent
  input wire logic         i_tx_info,        // Auto I frame
  input wire logic [6:0]   o_irq_status,     // Event flags
  input wire lafc_rxstat_s o_rx_frame_status // Frame status
);
  logic man_q;
  logic aw_q;
  logic rd_acc;
  // Mirror of the manual mode bit
  always_ff @(posedge i_clk) begin
    if (i_rst) man_q <= 1'b1;
    else if (i_psel && i_penable && i_pwrite && i_paddr == 12'h000) man_q <= i_pwdata[0];
  end
  // Mirror of the outstanding auto I frame
  always_ff @(posedge i_clk) begin
    if (i_rst) aw_q <= 1'b0;
    else if (!man_q && i_tx_info && i_tx_done) aw_q <= 1'b1;
    else if (i_ack_rx || i_rej_rx || man_q) aw_q <= 1'b0;
  end
  // Read access phase
  assign rd_acc = i_psel && i_penable && !i_pwrite;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  sequence s_isent;
    !man_q && i_tx_info && i_tx_done && !i_ack_rx && !o_irq_status[2];
  endsequence
  AST_STAT_RME: assert property (!$stable(o_rx_frame_status) |-> o_irq_status[0])
    else $error("status moved without message end");
  AST_IRQ_HOLD: assert property ((|($past(o_irq_status) & ~o_irq_status)) |-> $past(rd_acc && i_paddr == 12'h010))
    else $error("event flag lost without read");
  AST_XPR_MAN: assert property (man_q && i_tx_done |=> o_irq_status[2])
    else $error("no pool ready after manual send");
  AST_XPR_WAIT: assert property (s_isent |=> !o_irq_status[2])
    else $error("pool ready before acknowledge");
  AST_XMR_COLL: assert property (i_collision |=> o_irq_status[3])
    else $error("no repeat after collision");
  AST_XMR_REJ: assert property (!man_q && i_tx_info && i_rej_rx && aw_q |=> o_irq_status[3])
    else $error("no repeat after reject");
  AST_AUTO_MASK: assert property (man_q && rd_acc && i_paddr == 12'h00c |-> o_prdata == 32'h0)
    else $error("auto status visible in manual");
  AST_BUSY_MASK: assert property (man_q && rd_acc && i_paddr == 12'h008 |-> !o_prdata[3])
    else $error("peer busy visible in manual");
endmodule
bind lafc_frame_checker lafc_fc_chk chk_u (.i_clk(i_clk), .i_rst(i_rst), .i_psel(i_psel),
  .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
  .i_rej_rx(i_rej_rx), .i_ack_rx(i_ack_rx), .i_collision(i_collision), .i_tx_done(i_tx_done),
  .i_tx_info(i_tx_info), .o_irq_status(o_irq_status), .o_rx_frame_status(o_rx_frame_status));
`default_nettype wire

// ==== verif/lafc_peer.sv ====
`timescale 1ns/1ps
`default_nettype none
module lafc_peer (
  input  wire logic i_clk, // Bench clock
  output logic      o_bit, // Line bit
  output logic      o_vld  // Bit strobe
);
  int ones;
  initial begin
    o_bit = 1'b1;
    o_vld = 1'b0;
  end
  // One bit: data first, strobe 3 up, 4 down
  task automatic put(input logic b, input logic s);
    @(posedge i_clk);
    o_bit <= b;
    @(posedge i_clk);
    o_vld <= 1'b1;
    repeat (3) @(posedge i_clk);
    o_vld <= 1'b0;
    o_bit <= ~b;
    repeat (2) @(posedge i_clk);
    ones = (s && b) ? ones + 1 : 0;
    if (ones == 5) put(1'b0, 1'b0);
  endtask
  task automatic byte_out(input logic [7:0] b, input logic s);
    for (int i = 0; i < 8; i++) put(b[i], s);
  endtask
  // Frame: address, control, fill; n counts all octets
  task automatic frame(input logic [7:0] c, n, input logic [2:0] xb, input logic ab, no, od);
    logic [7:0] b;
    ones = 0;
    if (!no) byte_out(8'h7e, 1'b0);
    for (int i = 0; i < n; i++) begin
      b = (i == 0) ? {7'h0, od} : (i == 1 && !od) ? 8'h03 : (i == (od ? 1 : 2)) ? c : 8'h11;
      byte_out(b, 1'b1);
    end
    for (int i = 0; i < xb; i++) put(1'b0, 1'b1);
    byte_out(ab ? 8'hff : 8'h7e, 1'b0);
  endtask
endmodule
`default_nettype wire

// ==== verif/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb import lafc_pkg::*;;
  logic         i_clk, rst, psel, pen, pwr, fok, sok, full, tinfo, pbusy, rdy, err, rerr, rbit, rvld;
  logic [11:0]  padr;
  logic [31:0]  pwd, prd, rd, t;
  logic [5:0]   ev;
  logic [6:0]   irq;
  lafc_rxstat_s stat;
  int           n_fail = 0;
  int           n_checks = 0;
  // ctrl, octets, extra bits, fcs, sapi, full, abort, no open, one addr, end irq, mask, status
  logic [31:0]  rows [18] = '{32'h0006187c, 32'h00051800, 32'h03041800, 32'h0305187c, 32'h01051800,
    32'h00060878, 32'h01060800, 32'h03050878, 32'h00071880, 32'h00061000, 32'h00067878, 32'h03049878,
    32'h00057878, 32'h01065800, 32'h00061a49, 32'h01061a00, 32'h00061900, 32'h00081c52};
  lafc_frame_checker dut_u (.i_clk(i_clk), .i_rst(rst), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
    .i_paddr(padr), .i_pwdata(pwd), .o_prdata(prd), .o_pready(rdy), .o_pslverr(err), .i_rx_bit(rbit),
    .i_rx_bit_vld(rvld), .i_fcs_ok(fok), .i_sapi_ok(sok), .i_rx_full(full), .i_ack_rx(ev[0]), .i_rej_rx(ev[1]),
    .i_collision(ev[2]), .i_tx_done(ev[3]), .i_tx_info(tinfo), .i_sframe_tx(ev[4]), .i_peer_busy(pbusy),
    .i_tick(ev[5]), .o_irq_status(irq), .o_rx_frame_status(stat));
  lafc_peer peer_u (.i_clk(i_clk), .o_bit(rbit), .o_vld(rvld));
  task automatic chk(input logic [31:0] g, e);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d fails %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // One APB transfer, held until pready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge i_clk);
    psel <= 1'b1;
    pwr <= w;
    padr <= a;
    pwd <= d;
    @(posedge i_clk);
    pen <= 1'b1;
    do begin
      @(posedge i_clk);
    end while (rdy !== 1'b1);
    rd = prd;
    rerr = err;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic pulse(input int k);
    @(posedge i_clk);
    ev[k] <= 1'b1;
    @(posedge i_clk);
    ev[k] <= 1'b0;
    repeat (2) @(posedge i_clk);
  endtask
  // Send one frame, check the report, clear events
  task automatic row(input logic [31:0] r);
    @(posedge i_clk);
    fok <= r[12];
    sok <= r[11];
    full <= r[10];
    peer_u.frame(r[31:24], r[23:16], r[15:13], r[9], r[8], r[7]);
    repeat (20) @(posedge i_clk);
    chk(32'(irq[0]), 32'(r[6]));
    if (r[6]) chk(32'(stat & r[5:3]), 32'(r[2:0]));
    apb(1'b0, 12'h010, 32'h0);
  endtask
  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end
  initial begin
    repeat (60000) @(posedge i_clk);
    n_fail++;
    give_verdict;
  end
  // Main sequence
  initial begin
    rst = 1'b1;
    {psel, pen, pwr, fok, sok, full, tinfo, pbusy} = '0;
    padr = '0;
    pwd = '0;
    ev = '0;
    repeat (8) @(posedge i_clk);
    rst <= 1'b0;
    chk(32'(irq), 32'h0);
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, 32'h1);
    pbusy <= 1'b1;
    apb(1'b0, 12'h00c, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 12'h008, 32'h0);
    chk(32'(rd[3]), 32'h0);
    pbusy <= 1'b0;
    apb(1'b0, 12'hffc, 32'h0);
    chk(32'(rerr), 32'h1);
    foreach (rows[i]) row(rows[i]);
    apb(1'b1, 12'h000, 32'h5);
    row(32'h00067800);
    apb(1'b1, 12'h000, 32'h1);
    pulse(3);
    chk(32'(irq[2]), 32'h1);
    pulse(2);
    chk(32'(irq[3]), 32'h1);
    apb(1'b0, 12'h010, 32'h0);
    apb(1'b1, 12'h000, 32'h2);
    apb(1'b0, 12'h00c, 32'h0);
    chk(rd, 32'h1);
    pulse(4);
    apb(1'b0, 12'h00c, 32'h0);
    chk(rd, 32'h9);
    tinfo <= 1'b1;
    pulse(3);
    chk(32'(irq[2]), 32'h0);
    pulse(0);
    chk(32'(irq[2]), 32'h1);
    apb(1'b0, 12'h010, 32'h0);
    apb(1'b0, 12'h00c, 32'h0);
    chk(rd, 32'h1);
    apb(1'b0, 12'h008, 32'h0);
    chk(32'(rd[3]), 32'h0);
    pulse(3);
    apb(1'b1, 12'h004, 32'h1);
    apb(1'b0, 12'h00c, 32'h0);
    chk(rd, 32'h7);
    apb(1'b0, 12'h018, 32'h0);
    chk(32'(rd[15:12]), 32'h0);
    pulse(1);
    chk(32'(irq[3]), 32'h1);
    apb(1'b0, 12'h00c, 32'h0);
    chk(32'(rd[2:1]), 32'h0);
    pulse(3);
    apb(1'b1, 12'h014, 32'h5);
    apb(1'b0, 12'h014, 32'h0);
    t = rd;
    repeat (3) pulse(5);
    apb(1'b0, 12'h014, 32'h0);
    chk(rd, t);
    pbusy <= 1'b1;
    repeat (2) @(posedge i_clk);
    chk(32'(irq[4]), 32'h1);
    apb(1'b0, 12'h00c, 32'h0);
    chk(32'(rd[2]), 32'h1);
    apb(1'b1, 12'h000, 32'h1);
    apb(1'b0, 12'h00c, 32'h0);
    chk(rd, 32'h0);
    repeat (40) @(posedge i_clk);
    apb(1'b1, 12'h004, 32'hc);
    give_verdict;
  end
endmodule
`default_nettype wire
